/* File: design/ipa_pkg.sv */
// Constants shared by the indirect pointer access block
package ipa_pkg;

  // ************************************************************
  // Data space geometry
  // ************************************************************
  localparam int          PTR_COUNT  = 3;
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 8;
  localparam int          MEM_DEPTH  = 4096;

  // ************************************************************
  // Pointer blocks in the special-function space
  // ************************************************************
  localparam logic [11:0] PTR_BLOCK_TOP      = 12'hFE8;
  localparam logic [11:0] PTR_BLOCK_STEP     = 12'h008;
  localparam logic [11:0] INDIRECT_PORT_ONE  = 12'hFE7;
  localparam logic [2:0]  OFS_INDIRECT       = 3'h7;
  localparam logic [2:0]  OFS_POST_INC       = 3'h6;
  localparam logic [2:0]  OFS_POST_DEC       = 3'h5;
  localparam logic [2:0]  OFS_PRE_INC        = 3'h4;
  localparam logic [2:0]  OFS_PLUS_OFFSET    = 3'h3;
  localparam logic [2:0]  OFS_PTR_HIGH       = 3'h2;
  localparam logic [2:0]  OFS_PTR_LOW        = 3'h1;
  localparam logic [7:0]  NULL_READ_VALUE    = 8'h00;
  localparam logic [11:0] PTR_RESET          = 12'h000;

  // ************************************************************
  // AXI4-Lite register map
  // ************************************************************
  localparam logic [7:0]  REG_PTR0           = 8'h00;
  localparam logic [7:0]  REG_PTR1           = 8'h04;
  localparam logic [7:0]  REG_PTR2           = 8'h08;
  localparam logic [7:0]  REG_STATUS         = 8'h0C;
  localparam int          ST_NULL_READ       = 0;
  localparam int          ST_DROP_WRITE      = 1;
  localparam int          ST_PTR_LOAD        = 2;
  localparam logic [2:0]  STATUS_RESET       = 3'h0;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // ************************************************************
  // Read data source of a core access
  // ************************************************************
  typedef enum logic [1:0] {
    IPA_SRC_MEM  = 2'b00,
    IPA_SRC_PTR  = 2'b01,
    IPA_SRC_ZERO = 2'b10
  } ipa_src_t;

endpackage

/* File: design/ipa_data_mem.sv */
// Data memory with registered read port
`timescale 1ns/1ps
module ipa_data_mem (
  input  wire logic                       aclk,
  input  wire logic                       we,
  input  wire logic                       re,
  input  wire logic [ipa_pkg::ADDR_W-1:0] addr,
  input  wire logic [ipa_pkg::DATA_W-1:0] wdata,
  output logic      [ipa_pkg::DATA_W-1:0] rdata
);

  logic [ipa_pkg::DATA_W-1:0] mem [ipa_pkg::MEM_DEPTH];

  // ************************************************************
  // Write and registered read
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule

/* File: design/ipa_indirect_access.sv */
// Indirect pointer access unit with data memory and AXI4-Lite pointer registers
// Functional notes
// - Offset port addresses pointer plus working register
// - Pointer one indirect port sits at FE7h
// - Indirect read of a virtual port returns zero
// - Indirect write to a virtual port is dropped
// - Virtual write to pointer loads it, no step
// - Pointers are plain registers, directly accessible
// - Indirect access to other registers acts directly
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module ipa_indirect_access (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       core_req,
  input  wire logic                       core_we,
  input  wire logic [ipa_pkg::ADDR_W-1:0] core_addr,
  input  wire logic [ipa_pkg::DATA_W-1:0] core_wdata,
  input  wire logic [ipa_pkg::DATA_W-1:0] core_wreg,
  output logic      [ipa_pkg::DATA_W-1:0] core_rdata,
  output logic                            core_rvalid,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic      [1:0]                 s_axi_bresp,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [7:0]                 s_axi_araddr,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic      [31:0]                s_axi_rdata,
  output logic      [1:0]                 s_axi_rresp
);

  localparam int NP = ipa_pkg::PTR_COUNT;

  // ************************************************************
  // Pointer state and decode vectors
  // ************************************************************
  logic [NP-1:0][11:0] ptr;
  logic [NP-1:0][11:0] next_ptr;
  logic [NP-1:0]       port_hit;
  logic [NP-1:0]       tgt_virt;
  logic [NP-1:0]       tgt_high;
  logic [NP-1:0]       tgt_low;
  logic [NP-1:0]       axi_ptr_wr;
  logic [2:0]          status;
  logic [2:0]          next_status;
  logic                step_en;
  logic                ptr_load;
  logic [31:0]         wr_data;
  logic [3:0]          wr_strb;

  // ************************************************************
  // Pointer port selection
  // ************************************************************
  logic [1:0]  sel_idx;
  logic [2:0]  sel_kind;
  logic [11:0] sel_ptr;
  logic        sel_any;

  always_comb begin
    sel_idx  = 2'h0;
    sel_kind = 3'h0;
    sel_ptr  = ipa_pkg::PTR_RESET;
    for (int n = 0; n < NP; n++) begin
      if (port_hit[n]) begin
        sel_idx  = 2'(n);
        sel_kind = core_addr[2:0];
        sel_ptr  = ptr[n];
      end
    end
  end

  assign sel_any = |port_hit;

  wire        kind_plus  = sel_kind == ipa_pkg::OFS_PLUS_OFFSET;
  wire        kind_pre   = sel_kind == ipa_pkg::OFS_PRE_INC;
  wire        kind_pinc  = sel_kind == ipa_pkg::OFS_POST_INC;
  wire        kind_pdec  = sel_kind == ipa_pkg::OFS_POST_DEC;
  wire [11:0] index_ofs  = kind_plus ? {{4{core_wreg[7]}}, core_wreg}
                         : (kind_pre ? 12'h001 : 12'h000);
  wire [11:0] tgt_addr   = sel_any ? sel_ptr + index_ofs : core_addr;
  wire [11:0] step_val   = (kind_pinc || kind_pre) ? sel_ptr + 12'h001
                         : (kind_pdec ? sel_ptr - 12'h001 : sel_ptr);

  // ************************************************************
  // Per pointer decode of the core address and the target
  // ************************************************************
  for (genvar m = 0; m < NP; m++) begin : g_ptr
    localparam logic [11:0] BASE = ipa_pkg::PTR_BLOCK_TOP - 12'(m) * ipa_pkg::PTR_BLOCK_STEP;
    assign port_hit[m] = core_addr[11:3] == BASE[11:3]
                      && core_addr[2:0] >= ipa_pkg::OFS_PLUS_OFFSET;
    assign tgt_virt[m] = tgt_addr[11:3] == BASE[11:3]
                      && tgt_addr[2:0] >= ipa_pkg::OFS_PLUS_OFFSET;
    assign tgt_high[m] = tgt_addr == {BASE[11:3], ipa_pkg::OFS_PTR_HIGH};
    assign tgt_low[m]  = tgt_addr == {BASE[11:3], ipa_pkg::OFS_PTR_LOW};

    always_comb begin
      next_ptr[m] = ptr[m];
      if (axi_ptr_wr[m]) begin
        if (wr_strb[0]) begin
          next_ptr[m][7:0] = wr_data[7:0];
        end
        if (wr_strb[1]) begin
          next_ptr[m][11:8] = wr_data[11:8];
        end
      end
      if (step_en && sel_idx == 2'(m)) begin
        next_ptr[m] = step_val;
      end
      if (ptr_load && tgt_high[m]) begin
        next_ptr[m][11:8] = core_wdata[3:0];
      end
      if (ptr_load && tgt_low[m]) begin
        next_ptr[m][7:0] = core_wdata;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ptr[m] <= ipa_pkg::PTR_RESET;
      end else begin
        ptr[m] <= next_ptr[m];
      end
    end
  end

  // ************************************************************
  // Access outcome
  // ************************************************************
  wire tgt_virt_any = sel_any && (|tgt_virt);
  wire tgt_ptr_any  = |(tgt_high | tgt_low);
  wire null_read    = core_req && !core_we && tgt_virt_any;
  wire drop_write   = core_req && core_we && tgt_virt_any;
  assign ptr_load   = core_req && core_we && !tgt_virt_any && tgt_ptr_any;
  assign step_en    = core_req && sel_any && !drop_write && !(core_we && tgt_ptr_any);
  wire mem_we       = core_req && core_we && !tgt_virt_any && !tgt_ptr_any;
  wire mem_re       = core_req && !core_we;
  wire [7:0] ptr_byte;
  logic [7:0] ptr_byte_mux;

  always_comb begin
    ptr_byte_mux = 8'h00;
    for (int n = 0; n < NP; n++) begin
      if (tgt_high[n]) begin
        ptr_byte_mux = {4'h0, ptr[n][11:8]};
      end
      if (tgt_low[n]) begin
        ptr_byte_mux = ptr[n][7:0];
      end
    end
  end

  assign ptr_byte = ptr_byte_mux;

  assign next_status = core_req ? {sel_any && ptr_load, drop_write, null_read} : status;

  // ************************************************************
  // Data memory
  // ************************************************************
  logic [7:0] mem_rdata;

  ipa_data_mem u_mem (
    .aclk  (aclk),
    .we    (mem_we),
    .re    (mem_re),
    .addr  (tgt_addr),
    .wdata (core_wdata),
    .rdata (mem_rdata)
  );

  // ************************************************************
  // Read return pipeline
  // ************************************************************
  ipa_pkg::ipa_src_t rd_src;
  logic              rd_pend;
  logic [7:0]        rd_ptr_byte;
  wire  [7:0]        next_rdata = rd_src == ipa_pkg::IPA_SRC_ZERO ? ipa_pkg::NULL_READ_VALUE
                                : (rd_src == ipa_pkg::IPA_SRC_PTR ? rd_ptr_byte : mem_rdata);
  wire ipa_pkg::ipa_src_t next_src = null_read ? ipa_pkg::IPA_SRC_ZERO
                                   : (tgt_ptr_any ? ipa_pkg::IPA_SRC_PTR : ipa_pkg::IPA_SRC_MEM);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend     <= 1'b0;
      rd_src      <= ipa_pkg::IPA_SRC_MEM;
      rd_ptr_byte <= 8'h00;
      core_rvalid <= 1'b0;
      core_rdata  <= 8'h00;
      status      <= ipa_pkg::STATUS_RESET;
    end else begin
      rd_pend     <= mem_re;
      rd_src      <= next_src;
      rd_ptr_byte <= ptr_byte;
      core_rvalid <= rd_pend;
      core_rdata  <= rd_pend ? next_rdata : core_rdata;
      status      <= next_status;
    end
  end

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_idx;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  wire   wr_fire       = aw_held && w_held && !s_axi_bvalid;
  wire   wr_ok         = aw_idx < 4'(NP);

  for (genvar m = 0; m < NP; m++) begin : g_axi_wr
    assign axi_ptr_wr[m] = wr_fire && aw_idx == 4'(m);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_idx         <= 4'h0;
      wr_data        <= 32'h0000_0000;
      wr_strb        <= 4'h0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= ipa_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[7:4] == 4'h0 ? {2'b00, s_axi_awaddr[3:2]} : 4'hF;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held         <= 1'b1;
        wr_data        <= s_axi_wdata;
        wr_strb        <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? ipa_pkg::RESP_OKAY : ipa_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  wire        rd_map_ok  = s_axi_araddr[7:4] == 4'h0;
  wire [1:0]  rd_idx     = s_axi_araddr[3:2];
  wire        rd_is_stat = rd_map_ok && {4'h0, rd_idx, 2'b00} == ipa_pkg::REG_STATUS;
  wire        rd_is_ptr  = rd_map_ok && !rd_is_stat;
  wire [31:0] rd_word    = rd_is_stat ? {29'h0, status}
                         : (rd_is_ptr ? {20'h0, ptr[rd_idx]} : 32'h0000_0000);

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ipa_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_map_ok ? ipa_pkg::RESP_OKAY : ipa_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: tb/ipa_indirect_access_monitor.sv */
// Port level checks for the indirect pointer access unit
`timescale 1ns/1ps
module ipa_indirect_access_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        core_req,
  input wire logic        core_we,
  input wire logic [11:0] core_addr,
  input wire logic [7:0]  core_wdata,
  input wire logic [7:0]  core_rdata,
  input wire logic        core_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  wire logic rd_go = core_req && !core_we;
  wire logic hi_rd = rd_go && core_addr inside {12'hFDA, 12'hFE2, 12'hFEA};
  wire logic lo_wr = core_req && core_we && core_addr inside {12'hFD9, 12'hFE1, 12'hFE9};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (rd_go |-> ##2 core_rvalid)
    else $error("core read not answered in two cycles");
  a_answer_cause: assert property (core_rvalid |-> $past(rd_go, 2))
    else $error("core answer without a read");
  a_rdata_steady: assert property ($changed(core_rdata) |-> core_rvalid)
    else $error("core read data moved without an answer");
  a_high_nibble: assert property (hi_rd |-> ##2 core_rdata[7:4] == 4'h0)
    else $error("pointer high byte upper nibble not zero");
  a_low_reload: assert property (lo_wr ##1 !core_req ##1 rd_go && core_addr == $past(core_addr, 2)
    |-> ##2 core_rdata == $past(core_wdata, 4))
    else $error("pointer low byte not read back");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  a_read_reply: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("register read not answered next cycle");
  a_bad_offset: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:4] != 4'h0
    |=> s_axi_rresp == ipa_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped register read not refused");
  c_high_read: cover property (hi_rd);
  c_resp_stall: cover property (s_axi_bvalid && !s_axi_bready);
  c_read_error: cover property (s_axi_rvalid && s_axi_rresp == ipa_pkg::RESP_SLVERR);
endmodule

bind ipa_indirect_access ipa_indirect_access_monitor mon_u (
  .aclk, .aresetn, .core_req, .core_we, .core_addr, .core_wdata, .core_rdata, .core_rvalid, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp);

/* File: tb/ipa_core_model.sv */
// Processor core model issuing data memory accesses
`timescale 1ns/1ps
module ipa_core_model (
  input wire logic        aclk,
  output logic            core_req,
  output logic            core_we,
  output logic [11:0]     core_addr,
  output logic [7:0]      core_wdata,
  output logic [7:0]      core_wreg,
  input wire logic [7:0]  core_rdata,
  input wire logic        core_rvalid
);
  initial begin
    core_req = 1'b0;
    core_we = 1'b0;
    core_addr = 12'h000;
    {core_wdata, core_wreg} = 16'h0000;
  end
  task automatic acc(input logic we, input logic [11:0] a, input logic [7:0] d, w, output logic [7:0] rd);
    rd = 8'hXX;
    @(posedge aclk);
    core_req <= 1'b1;
    core_we <= we;
    core_addr <= a;
    core_wdata <= d;
    core_wreg <= w;
    @(posedge aclk);
    core_req <= 1'b0;
    core_addr <= ~a;
    core_wdata <= ~d;
    core_wreg <= ~w;
    if (!we) begin
      @(posedge aclk);
      @(negedge aclk);
      if (core_rvalid === 1'b1)
        rd = core_rdata;
    end
  endtask
endmodule

/* File: tb/ipa_indirect_access_tb_top.sv */
// Self-checking bench for the indirect pointer access unit
`timescale 1ns/1ps
module ipa_indirect_access_tb_top;
  logic        aclk, aresetn, core_req, core_we, core_rvalid, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] core_addr, p;
  logic [7:0]  core_wdata, core_wreg, core_rdata, s_axi_awaddr, s_axi_araddr, v, w, d8;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          err_total, check_count, i, n;

  always #5 aclk = ~aclk;
  ipa_indirect_access dut_u (.aclk, .aresetn, .core_req, .core_we, .core_addr, .core_wdata, .core_wreg,
    .core_rdata, .core_rvalid, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  ipa_core_model core_u (.aclk, .core_req, .core_we, .core_addr, .core_wdata, .core_wreg, .core_rdata,
    .core_rvalid);

  function automatic logic [11:0] vport(input int k, input logic [2:0] o);
    return ipa_pkg::PTR_BLOCK_TOP - 12'(k) * ipa_pkg::PTR_BLOCK_STEP + 12'(o);
  endfunction
  function automatic logic [11:0] plus(input logic [11:0] b, input logic [7:0] o);
    return b + {{4{o[7]}}, o};
  endfunction
  task automatic chk(input string s, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] dw, output logic [31:0] dr);
    logic ha, hw, hr, fin;
    int   k, dl;
    dl = $urandom % 4;
    @(posedge aclk);
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= dw;
    s_axi_wstrb <= 4'h3 | 4'($urandom);
    fin = 1'b0;
    for (k = 0; !fin; k++) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hr = s_axi_arvalid && s_axi_arready;
      fin = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
      dr = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hr) s_axi_arvalid <= 1'b0;
      s_axi_bready <= wr && !fin && k >= dl;
      s_axi_rready <= !wr && !fin && k >= dl;
    end
  endtask
  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
    axi(1'b0, a, 32'h0, d);
    chk(s, d, e);
  endtask
  task automatic cchk(input string s, input logic [11:0] a, input logic [7:0] wr, e);
    core_u.acc(1'b0, a, 8'h00, wr, d8);
    chk(s, 32'(d8), 32'(e));
  endtask
  task automatic cwr(input logic [11:0] a, input logic [7:0] dv, wr);
    core_u.acc(1'b1, a, dv, wr, d8);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    test_done();
  end
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    void'($urandom(32'h552A));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 4; i++)
      rchk("reset value", 8'(4 * i), 32'h0);
    rchk("unmapped read", 8'h10, 32'h0);
    chk("unmapped resp", 32'(r), 32'(ipa_pkg::RESP_SLVERR));
    axi(1'b1, ipa_pkg::REG_STATUS, 32'h7, d);
    chk("status write resp", 32'(r), 32'(ipa_pkg::RESP_SLVERR));
    for (n = 0; n < 3; n++) begin
      p = 12'($urandom);
      v = 8'($urandom);
      axi(1'b1, 8'(4 * n), 32'(p), d);
      cchk("high byte", vport(n, ipa_pkg::OFS_PTR_HIGH), 8'h00, 8'(p[11:8]));
      cwr(vport(n, ipa_pkg::OFS_PTR_LOW), v, 8'h00);
      cchk("low byte", vport(n, ipa_pkg::OFS_PTR_LOW), 8'h00, v);
      rchk("pointer pair", 8'(4 * n), 32'({p[11:8], v}));
    end
    for (i = 0; i < 6; i++) begin
      n = $urandom % 3;
      p = 12'h100 + 12'($urandom % 1536);
      w = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom);
      v = 8'($urandom);
      axi(1'b1, 8'(4 * n), 32'(p), d);
      cwr(plus(p, w), v, 8'h00);
      cchk("offset read", vport(n, ipa_pkg::OFS_PLUS_OFFSET), w, v);
      cwr(vport(n, ipa_pkg::OFS_PLUS_OFFSET), ~v, w);
      cchk("offset write", plus(p, w), 8'h00, ~v);
      rchk("pointer kept", 8'(4 * n), 32'(p));
    end
    axi(1'b1, ipa_pkg::REG_PTR1, 32'h300, d);
    cwr(12'h300, 8'h5A, 8'h00);
    cchk("port one read", ipa_pkg::INDIRECT_PORT_ONE, 8'h00, 8'h5A);
    axi(1'b1, ipa_pkg::REG_PTR0, 32'(ipa_pkg::INDIRECT_PORT_ONE), d);
    cchk("nested read", vport(0, ipa_pkg::OFS_INDIRECT), 8'h00, ipa_pkg::NULL_READ_VALUE);
    rchk("null status", ipa_pkg::REG_STATUS, 32'h1 << ipa_pkg::ST_NULL_READ);
    cwr(vport(0, ipa_pkg::OFS_POST_INC), 8'hA5, 8'h00);
    rchk("drop status", ipa_pkg::REG_STATUS, 32'h1 << ipa_pkg::ST_DROP_WRITE);
    cchk("nested write", 12'h300, 8'h00, 8'h5A);
    rchk("no step", ipa_pkg::REG_PTR0, 32'(ipa_pkg::INDIRECT_PORT_ONE));
    axi(1'b1, ipa_pkg::REG_PTR2, 32'(vport(2, ipa_pkg::OFS_PTR_LOW)), d);
    v = 8'($urandom);
    cwr(vport(2, ipa_pkg::OFS_POST_DEC), v, 8'h00);
    rchk("self load", ipa_pkg::REG_PTR2, 32'({4'hF, v}));
    rchk("load status", ipa_pkg::REG_STATUS, 32'h1 << ipa_pkg::ST_PTR_LOAD);
    axi(1'b1, ipa_pkg::REG_PTR0, 32'(vport(1, ipa_pkg::OFS_PTR_HIGH)), d);
    cwr(vport(0, ipa_pkg::OFS_POST_INC), 8'h0B, 8'h00);
    rchk("cross load", ipa_pkg::REG_PTR1, 32'hB00);
    rchk("cross no step", ipa_pkg::REG_PTR0, 32'(vport(1, ipa_pkg::OFS_PTR_HIGH)));
    axi(1'b1, ipa_pkg::REG_PTR0, 32'(vport(2, ipa_pkg::OFS_PTR_LOW)), d);
    cchk("register read", vport(0, ipa_pkg::OFS_INDIRECT), 8'h00, v);
    test_done();
  end
endmodule
